//--- dv/fmtc_host_model.sv
// Host model: drives direction, data, test and level pins of the modem.
// Assumes the bench clock and the line outputs of the block.
`timescale 1ns/1ps
`default_nettype none
module fmtc_host_model
  import fmtc_pkg::*;
(
  // Clock
  input  wire logic                 aclk,
  // Block side
  input  wire fmtc_pkg::fmtc_line_t line,
  output var  fmtc_pkg::fmtc_pins_t pins
);
  logic [15:0] hi_cnt;
  logic        clk_q;

  initial begin
    pins = '0;
    pins.rx_tx_select = 1'b1;
    hi_cnt = 16'h0;
    clk_q = 1'b0;
  end

  // Next bit after a falling edge, so it is stable at the rising one
  always @(posedge aclk) begin
    clk_q <= line.shared_bit_clock;
    if (clk_q && !line.shared_bit_clock) begin
      pins.tx_data <= ~pins.tx_data;
    end
    if (!pins.rx_tx_select) begin
      hi_cnt <= 16'h0;
    end else if (hi_cnt != 16'hFFFF) begin
      hi_cnt <= hi_cnt + 16'h1;
    end
  end

  // Modes as {disable, fast, recovery, ext filter, filter input}
  task automatic cfg(input logic [4:0] m, input logic [FB_W-1:0] fb);
    @(posedge aclk);
    {pins.auto_return_disable, pins.fast_timeout_select, pins.recovery_test_input,
     pins.external_filter_select, pins.filter_test_in} <= m;
    pins.level_feedback_in <= fb;
  endtask

  task automatic go_tx();
    @(posedge aclk);
    while (hi_cnt < 16'h01A0) begin
      @(posedge aclk);
    end
    pins.rx_tx_select <= 1'b0;
  endtask

  task automatic go_rx();
    @(posedge aclk);
    pins.rx_tx_select <= 1'b1;
  endtask
endmodule
`default_nettype wire

//--- dv/fmtc_top_monitor.sv
// Checker of the FSK modem transmit control, on the top ports only.
// Assumes binding into fmtc_top, with its timeout parameters handed on.
`timescale 1ns/1ps
`default_nettype none
module fmtc_top_monitor
  import fmtc_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = 2000,
  parameter int unsigned FAST_TO_CYCLES = 500
) (
  // Clock and reset
  input wire logic                 aclk,
  input wire logic                 aresetn,
  // Modem pins
  input wire fmtc_pkg::fmtc_pins_t pins,
  input wire fmtc_pkg::fmtc_line_t line
);
  logic [31:0]       lo_cnt;
  logic [31:0]       lim;
  logic [15:0]       chg_cnt;
  logic [GAIN_W-1:0] gain_q;

  assign lim = pins.fast_timeout_select ? 32'(FAST_TO_CYCLES) : 32'(TIMEOUT_CYCLES);

  // Cycles with direction low, and cycles since the last gain change
  always_ff @(posedge aclk) begin
    gain_q <= line.output_level_control;
    if (!aresetn || pins.rx_tx_select) begin
      lo_cnt <= 32'h0;
    end else begin
      lo_cnt <= lo_cnt + 32'h1;
    end
    if (!aresetn || line.output_level_control != gain_q) begin
      chg_cnt <= 16'h0;
    end else if (chg_cnt != 16'hFFFF) begin
      chg_cnt <= chg_cnt + 16'h1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_rx_held;
    pins.rx_tx_select [*5];
  endsequence
  sequence s_tx_entry;
    pins.rx_tx_select [*4] ##1 (!pins.rx_tx_select) [*5];
  endsequence

  property p_reset_state;
    $rose(aresetn) |-> line.power_down && !line.tx_active && line.output_level_control == GAIN_MIN;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("Outputs not cleared by reset");
  property p_wake;
    $rose(aresetn) |-> ##3 !line.power_down;
  endproperty
  a_wake: assert property (p_wake)
    else $error("Power-down kept after reset release");
  property p_rx_mode;
    s_rx_held |-> !line.tx_active;
  endproperty
  a_rx_mode: assert property (p_rx_mode)
    else $error("Transmit while direction high");
  property p_tx_mode;
    s_tx_entry |-> line.tx_active;
  endproperty
  a_tx_mode: assert property (p_tx_mode)
    else $error("No transmit after direction low");
  property p_no_early;
    lo_cnt > 32'h8 && lo_cnt < lim |-> line.tx_active;
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("Transmit ended before timeout");
  property p_timeout;
    !pins.auto_return_disable && lo_cnt > lim + 32'h10 |-> !line.tx_active;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("Transmit kept past timeout");
  property p_no_timeout;
    pins.auto_return_disable && lo_cnt > 32'h8 |-> line.tx_active;
  endproperty
  a_no_timeout: assert property (p_no_timeout)
    else $error("Timeout while switchover disabled");
  property p_ext_filter;
    (line.tx_active && pins.external_filter_select && $stable(pins.filter_test_in)) [*5]
      |-> line.tx_filter_drive == pins.filter_test_in;
  endproperty
  a_ext_filter: assert property (p_ext_filter)
    else $error("Filter drive not from test input");
  property p_drive_idle;
    (!line.tx_active) [*2] |-> !line.tx_filter_drive;
  endproperty
  a_drive_idle: assert property (p_drive_idle)
    else $error("Filter driven in receive mode");
  property p_recovery;
    (pins.auto_return_disable && pins.rx_tx_select && $stable(pins.recovery_test_input)) [*5]
      |-> line.demodulated_out == pins.recovery_test_input;
  endproperty
  a_recovery: assert property (p_recovery)
    else $error("Recovery input not routed");
  property p_gain_step;
    !$stable(line.output_level_control) |->
      (line.output_level_control == $past(line.output_level_control) + 5'h01
        && $past(line.output_level_control) != GAIN_MAX)
      || (line.output_level_control == $past(line.output_level_control) - 5'h01
        && $past(line.output_level_control) != GAIN_MIN);
  endproperty
  a_gain_step: assert property (p_gain_step)
    else $error("Gain moved by other than one step");
  property p_gain_rate;
    !$stable(line.output_level_control) |-> chg_cnt > 16'h4E20;
  endproperty
  a_gain_rate: assert property (p_gain_rate)
    else $error("Gain changed twice in one period");
endmodule

bind fmtc_top fmtc_top_monitor #(
  .TIMEOUT_CYCLES (TIMEOUT_CYCLES),
  .FAST_TO_CYCLES (FAST_TO_CYCLES)
) u_monitor (
  .aclk    (aclk),
  .aresetn (aresetn),
  .pins    (pins),
  .line    (line)
);
`default_nettype wire

//--- dv/fmtc_top_tb.sv
// Self-checking bench of the FSK modem transmit control.
// Assumes the host model and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module fmtc_top_tb;
  import fmtc_pkg::*;
  localparam int unsigned TO_CYC  = 2000;
  localparam int unsigned FTO_CYC = 500;
  logic        aclk, aresetn;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rdat;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  fmtc_pins_t  pins;
  fmtc_line_t  line;
  int          n_mismatch, n_tests;

  fmtc_top #(.TIMEOUT_CYCLES(TO_CYC), .FAST_TO_CYCLES(FTO_CYC)) DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pins(pins), .line(line)
  );
  fmtc_host_model u_host (.aclk(aclk), .line(line), .pins(pins));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_tx(input logic e);
    chk({31'h0, line.tx_active}, {31'h0, e});
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({29'h0, bvalid, bresp}, {29'h0, 1'b1, er});
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    chk({29'h0, rvalid, rresp}, {29'h0, 1'b1, er});
  endtask

  task automatic t_regs();
    axi_rd(REG_CTRL, RESP_OKAY, rdat);
    chk(rdat, 32'h1);
    axi_rd(REG_THRESH, RESP_OKAY, rdat);
    chk(rdat, 32'h0C000400);
    axi_rd(8'h10, RESP_SLVERR, rdat);
    chk(rdat, 32'h0);
    axi_wr(8'h10, 32'h1, RESP_SLVERR);
    axi_wr(REG_STATUS, 32'hFFFFFFFF, RESP_OKAY);
    axi_rd(REG_STATUS, RESP_OKAY, rdat);
    chk(rdat, 32'h0);
  endtask

  task automatic t_midreset();
    u_host.go_tx();
    wait_cyc(10);
    chk_tx(1'b1);
    aresetn <= 1'b0;
    wait_cyc(4);
    chk({25'h0, line.power_down, line.tx_active, line.output_level_control}, 32'h40);
    u_host.go_rx();
    wait_cyc(4);
    aresetn <= 1'b1;
    wait_cyc(10);
    chk({29'h0, line.power_down, line.tx_active, line.rx_data}, 32'h0);
  endtask

  task automatic t_timeout();
    u_host.cfg(5'h00, 12'h300);
    u_host.go_tx();
    wait_cyc(TO_CYC - 100);
    chk_tx(1'b1);
    wait_cyc(200);
    chk_tx(1'b0);
    axi_rd(REG_STATUS, RESP_OKAY, rdat);
    chk({30'h0, rdat[1:0]}, 32'h2);
    u_host.go_rx();
    u_host.go_tx();
    wait_cyc(TO_CYC - 100);
    chk_tx(1'b1);
    u_host.go_rx();
  endtask

  task automatic t_fast();
    u_host.cfg(5'h08, 12'h300);
    u_host.go_tx();
    wait_cyc(FTO_CYC - 100);
    chk_tx(1'b1);
    wait_cyc(200);
    chk_tx(1'b0);
    u_host.go_rx();
  endtask

  task automatic t_level();
    u_host.cfg(5'h14, 12'h300);
    wait_cyc(10);
    chk({31'h0, line.demodulated_out}, 32'h1);
    axi_wr(REG_THRESH, 32'h03000300, RESP_OKAY);
    u_host.cfg(5'h13, 12'h300);
    u_host.go_tx();
    wait_cyc(10);
    chk({30'h0, line.tx_filter_drive, line.shared_bit_clock}, 32'h2);
    u_host.cfg(5'h12, 12'h300);
    wait_cyc(10);
    chk({31'h0, line.tx_filter_drive}, 32'h0);
    wait_cyc(TO_CYC + 200);
    chk_tx(1'b1);
    wait_cyc(29000);
    axi_rd(REG_STATUS, RESP_OKAY, rdat);
    chk({19'h0, rdat[12:0]}, 32'h1);
    axi_wr(REG_THRESH, 32'h02000100, RESP_OKAY);
    wait_cyc(28500);
    axi_rd(REG_STATUS, RESP_OKAY, rdat);
    chk({19'h0, rdat[12:0]}, 32'h9);
    axi_wr(REG_THRESH, 32'h0C000400, RESP_OKAY);
    wait_cyc(28500);
    axi_rd(REG_STATUS, RESP_OKAY, rdat);
    chk({28'h0, rdat[3:0]}, 32'h5);
    chk({31'h0, rdat[12:8] != 5'h00}, 32'h1);
    axi_rd(REG_PEAK, RESP_OKAY, rdat);
    chk(rdat, 32'h300);
    u_host.go_rx();
  endtask

  task automatic results();
    $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #600000;
    n_mismatch++;
    $display("ERROR %0t: watchdog expired", $time);
    results();
  end

  initial begin
    aresetn = 1'b0;
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    wstrb = 4'hF;
    n_mismatch = 0;
    n_tests = 0;
    wait_cyc(8);
    chk({26'h0, line.power_down, line.output_level_control}, 32'h20);
    aresetn <= 1'b1;
    t_regs();
    t_midreset();
    t_timeout();
    t_fast();
    t_level();
    results();
  end
endmodule
`default_nettype wire

//--- src/fmtc_pkg.sv
// Constants, field layouts and carrier types of the FSK modem transmit control.
// Assumes a 200 MHz system clock that stands in for the crystal time base.
package fmtc_pkg;

  // Clock and crystal time base
  localparam int unsigned CLK_HZ      = 200000000;
  localparam int unsigned CLK_MHZ     = 200;
  localparam int unsigned XTAL_HZ     = 11059200;
  localparam int          XACC_W      = 28;

  // Baud rates and level loop rate
  localparam int unsigned BAUD_SLOW   = 600;
  localparam int unsigned BAUD_FAST   = 1200;
  localparam int unsigned ALC_RATE_HZ = 7200;
  localparam int          BIT_W       = 14;
  localparam logic [BIT_W-1:0] HALF_SLOW = BIT_W'(XTAL_HZ / (2 * BAUD_SLOW));
  localparam logic [BIT_W-1:0] HALF_FAST = BIT_W'(XTAL_HZ / (2 * BAUD_FAST));
  localparam int          ALC_W       = 11;
  localparam logic [ALC_W-1:0] ALC_TICKS = ALC_W'(XTAL_HZ / ALC_RATE_HZ);

  // Carrier synthesis, frequencies in Hz
  localparam int          NCO_W       = 24;
  localparam longint      F_S0_ONE    = 81750;
  localparam longint      F_S0_ZERO   = 82350;
  localparam longint      F_S1_ONE    = 67200;
  localparam longint      F_S1_ZERO   = 67800;
  localparam longint      F_F0_ONE    = 71400;
  localparam longint      F_F0_ZERO   = 72600;
  localparam longint      F_F1_ONE    = 85950;
  localparam longint      F_F1_ZERO   = 87150;
  function automatic logic [NCO_W-1:0] nco_inc(input longint f_hz);
    nco_inc = NCO_W'((f_hz * (64'd1 << NCO_W)) / XTAL_HZ);
  endfunction

  // Times and derived cycle counts
  localparam int unsigned TIMEOUT_S      = 3;
  localparam int unsigned FAST_TIMEOUT_US = 1480;
  localparam int unsigned SETTLE_NS      = 34700;
  localparam int unsigned DETECT_NS      = 104200;
  localparam int unsigned TIMEOUT_CYC    = TIMEOUT_S * CLK_HZ;
  localparam int unsigned FAST_TO_CYC    = FAST_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned SETTLE_CYC     = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DETECT_CYC     = (DETECT_NS * CLK_MHZ) / 1000;
  localparam int          TO_W           = 30;
  localparam int          WIN_W          = 16;

  // Level control
  localparam int          GAIN_W      = 5;
  localparam logic [GAIN_W-1:0] GAIN_MAX = 5'h1F;
  localparam logic [GAIN_W-1:0] GAIN_MIN = 5'h00;
  localparam int          FB_W        = 12;

  // Register map (byte addresses) and fields
  localparam int          AXI_AW      = 8;
  localparam logic [AXI_AW-1:0] REG_CTRL   = 8'h00;
  localparam logic [AXI_AW-1:0] REG_THRESH = 8'h04;
  localparam logic [AXI_AW-1:0] REG_STATUS = 8'h08;
  localparam logic [AXI_AW-1:0] REG_PEAK   = 8'h0C;
  localparam int          CTRL_LOOP_EN = 0;
  localparam int          THR_LO_LSB   = 0;
  localparam int          THR_HI_LSB   = 16;
  localparam logic [FB_W-1:0] THR_LO_RST = 12'h400;
  localparam logic [FB_W-1:0] THR_HI_RST = 12'hC00;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FMTC_ALC_IDLE   = 2'h0,
    FMTC_ALC_SETTLE = 2'h1,
    FMTC_ALC_DETECT = 2'h3,
    FMTC_ALC_WAIT   = 2'h2
  } fmtc_alc_t;

  typedef enum logic [1:0] {
    FMTC_DEC_HOLD = 2'h0,
    FMTC_DEC_UP   = 2'h1,
    FMTC_DEC_DOWN = 2'h2
  } fmtc_dec_t;

  // Pins from outside the clock domain
  typedef struct packed {
    logic            rx_tx_select;
    logic            tx_data;
    logic            baud_rate_select;
    logic            channel_select;
    logic            auto_return_disable;
    logic            fast_timeout_select;
    logic            recovery_test_input;
    logic            external_filter_select;
    logic            demod_in;
    logic            filter_test_in;
    logic [FB_W-1:0] level_feedback_in;
  } fmtc_pins_t;

  // Pins toward the line side
  typedef struct packed {
    logic              shared_bit_clock;
    logic              rx_data;
    logic              demodulated_out;
    logic              tx_filter_drive;
    logic              tx_active;
    logic              power_down;
    logic [GAIN_W-1:0] output_level_control;
  } fmtc_line_t;

endpackage

//--- src/fmtc_top.sv
// FSK modem transmit control: direction, bit clocks, carrier, level loop, registers.
// Assumes pins arrive asynchronously and an AXI4-Lite master on aclk.
//
// Notes on behaviour
// - Direction select low means transmit, high means receive.
// - Direction low beyond three seconds forces receive mode.
// - Transmit mode drives bit clock pin with baud-rate transmit clock.
// - Transmit data sampled at each bit clock rising edge.
// - Baud select low: 600 baud, carriers per channel select.
// - Baud select high: 1200 baud, carriers per channel select.
// - All carriers and clocks derive from the crystal time base.
// - Level control holds one of 32 gain settings.
// - Gain updates at 7200 Hz, one step each.
// - Each period: settling interval, then peak detection interval.
// - Peak below lower threshold raises gain one step.
// - Peak within thresholds inclusive keeps gain.
// - Peak above upper threshold lowers gain one step.
// - Reset low clears all logic and signals power-down; loop enable, thresholds and direction stages load non-zero values.
// - First test input stops auto switchover, routes third test input to recovery.
// - Second test input shortens the switchover delay.
// - Fourth test input feeds filter from external test input.
// - Bit clock pin carries receive or transmit clock by mode.
// - Shortened switchover delay is 1.48 ms.
// - First test input high with direction low transmits continuously.
// - Receive data updates on recovered clock rising edge.
`timescale 1ns/1ps
`default_nettype none
module fmtc_top
  import fmtc_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = fmtc_pkg::TIMEOUT_CYC,
  parameter int unsigned FAST_TO_CYCLES = fmtc_pkg::FAST_TO_CYC,
  parameter int unsigned SETTLE_CYCLES  = fmtc_pkg::SETTLE_CYC,
  parameter int unsigned DETECT_CYCLES  = fmtc_pkg::DETECT_CYC
) (
  // Clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // AXI4-Lite write
  input  wire logic [fmtc_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [fmtc_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // Modem pins
  input  wire fmtc_pkg::fmtc_pins_t        pins,
  output fmtc_pkg::fmtc_line_t             line
);
  import fmtc_pkg::*;

  typedef struct packed {
    fmtc_pins_t        sync1;
    fmtc_pins_t        sync2;
    logic [XACC_W-1:0] xacc;
    logic              dir_q;
    logic [TO_W-1:0]   to_cnt;
    logic              timed_out;
    logic              tx_mode;
    logic [BIT_W-1:0]  bit_cnt;
    logic              tx_clk;
    logic              tx_bit;
    logic [NCO_W-1:0]  nco;
    logic [BIT_W-1:0]  rx_cnt;
    logic              rx_clk;
    logic              rx_prev;
    logic              rx_data;
    logic              demod_out;
    logic              shared_clk;
    logic              filt_drive;
    logic [ALC_W-1:0]  alc_cnt;
    fmtc_alc_t         alc_st;
    logic [WIN_W-1:0]  win_cnt;
    logic [FB_W-1:0]   peak;
    logic [FB_W-1:0]   last_peak;
    logic [FB_W-1:0]   fb_q;
    logic [GAIN_W-1:0] gain;
    fmtc_dec_t         last_dec;
    logic              pd;
    logic              loop_en;
    logic [FB_W-1:0]   thr_lo;
    logic [FB_W-1:0]   thr_hi;
    logic              aw_got;
    logic [AXI_AW-1:0] aw_addr;
    logic              w_got;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } fmtc_state_t;

  fmtc_state_t s;
  fmtc_state_t next_s;

  logic              xtick;
  logic [XACC_W-1:0] xsum;
  logic [BIT_W-1:0]  half;
  logic [NCO_W-1:0]  inc;
  logic [TO_W-1:0]   to_limit;
  logic              rec_in;
  logic [31:0]       cur;
  logic [31:0]       merged;

  always_comb begin
    next_s = s;
    // Pin synchronisers
    next_s.sync1 = pins;
    next_s.sync2 = s.sync1;
    next_s.dir_q = s.sync2.rx_tx_select;
    next_s.pd = 1'b0;

    // Crystal time base as a fractional enable
    xsum = s.xacc + XACC_W'(XTAL_HZ);
    xtick = (xsum >= XACC_W'(CLK_HZ));
    next_s.xacc = xtick ? xsum - XACC_W'(CLK_HZ) : xsum;

    // Mode and timeout
    to_limit = s.sync2.fast_timeout_select ? TO_W'(FAST_TO_CYCLES)
                                           : TO_W'(TIMEOUT_CYCLES);
    if (s.sync2.rx_tx_select) begin
      next_s.to_cnt = '0;
      next_s.timed_out = 1'b0;
    end else if (s.dir_q) begin
      next_s.to_cnt = '0;
    end else if (s.sync2.auto_return_disable) begin
      next_s.to_cnt = '0;
    end else if (s.to_cnt >= to_limit) begin
      next_s.timed_out = 1'b1;
    end else begin
      next_s.to_cnt = s.to_cnt + 1'b1;
    end
    next_s.tx_mode = ~s.sync2.rx_tx_select & ~next_s.timed_out;

    // Transmit bit clock and data sampling
    half = s.sync2.baud_rate_select ? HALF_FAST : HALF_SLOW;
    if (!s.tx_mode) begin
      next_s.bit_cnt = '0;
      next_s.tx_bit = s.sync2.tx_data;
      next_s.tx_clk = 1'b0;
    end else if (xtick) begin
      if (s.bit_cnt >= half - 1'b1) begin
        next_s.bit_cnt = '0;
        next_s.tx_clk = ~s.tx_clk;
        if (!s.tx_clk) begin
          next_s.tx_bit = s.sync2.tx_data;
        end
      end else begin
        next_s.bit_cnt = s.bit_cnt + 1'b1;
      end
    end

    // Carrier synthesis
    case ({s.sync2.baud_rate_select, s.sync2.channel_select, s.tx_bit})
      3'h0:    inc = nco_inc(F_S0_ZERO);
      3'h1:    inc = nco_inc(F_S0_ONE);
      3'h2:    inc = nco_inc(F_S1_ZERO);
      3'h3:    inc = nco_inc(F_S1_ONE);
      3'h4:    inc = nco_inc(F_F0_ZERO);
      3'h5:    inc = nco_inc(F_F0_ONE);
      3'h6:    inc = nco_inc(F_F1_ZERO);
      default: inc = nco_inc(F_F1_ONE);
    endcase
    if (!s.tx_mode) begin
      next_s.nco = '0;
    end else if (xtick) begin
      next_s.nco = s.nco + inc;
    end
    next_s.filt_drive = s.tx_mode & (s.sync2.external_filter_select ? s.sync2.filter_test_in
                                                                   : s.nco[NCO_W-1]);

    // Receive clock recovery
    rec_in = s.sync2.auto_return_disable ? s.sync2.recovery_test_input
                                         : s.sync2.demod_in;
    next_s.demod_out = rec_in;
    next_s.rx_prev = rec_in;
    // Phase restarts at each data edge
    if (s.tx_mode) begin
      next_s.rx_cnt = '0;
      next_s.rx_clk = 1'b0;
    end else if (rec_in != s.rx_prev) begin
      next_s.rx_cnt = '0;
      next_s.rx_clk = 1'b0;
    end else if (xtick) begin
      if (s.rx_cnt >= half - 1'b1) begin
        next_s.rx_cnt = '0;
        next_s.rx_clk = ~s.rx_clk;
        if (!s.rx_clk) begin
          next_s.rx_data = rec_in;
        end
      end else begin
        next_s.rx_cnt = s.rx_cnt + 1'b1;
      end
    end
    next_s.shared_clk = s.tx_mode ? s.tx_clk : s.rx_clk;

    // Level control loop
    if (xtick) begin
      next_s.alc_cnt = (s.alc_cnt >= ALC_TICKS - 1'b1) ? '0 : s.alc_cnt + 1'b1;
    end
    next_s.fb_q = s.sync2.level_feedback_in;
    if (s.win_cnt != '1) begin
      next_s.win_cnt = s.win_cnt + 1'b1;
    end
    case (s.alc_st)
      FMTC_ALC_IDLE: begin
        if (s.tx_mode && s.loop_en) begin
          next_s.alc_st = FMTC_ALC_WAIT;
        end
      end

      FMTC_ALC_SETTLE: begin
        if (s.win_cnt >= WIN_W'(SETTLE_CYCLES - 1)) begin
          next_s.alc_st = FMTC_ALC_DETECT;
          next_s.win_cnt = '0;
          next_s.peak = '0;
        end
      end

      FMTC_ALC_DETECT: begin
        // Feedback word taken only when seen twice
        if (s.sync2.level_feedback_in == s.fb_q && s.fb_q > s.peak) begin
          next_s.peak = s.fb_q;
        end
        // Also ends in the last tick slot: settle and detect together exceed a period
        if (s.win_cnt >= WIN_W'(DETECT_CYCLES - 1)
            || s.alc_cnt >= ALC_TICKS - 1'b1) begin
          next_s.alc_st = FMTC_ALC_WAIT;
        end
      end

      // Decision at the period end
      default: begin
        if (xtick && s.alc_cnt >= ALC_TICKS - 1'b1) begin
          next_s.win_cnt = '0;
          next_s.alc_st = FMTC_ALC_SETTLE;
          next_s.last_peak = s.peak;
          if (s.tx_mode) begin
            if (s.peak < s.thr_lo) begin
              next_s.last_dec = FMTC_DEC_UP;
              if (s.gain != GAIN_MAX) next_s.gain = s.gain + 1'b1;
            end else if (s.peak > s.thr_hi) begin
              next_s.last_dec = FMTC_DEC_DOWN;
              if (s.gain != GAIN_MIN) next_s.gain = s.gain - 1'b1;
            end else begin
              next_s.last_dec = FMTC_DEC_HOLD;
            end
          end
          next_s.peak = s.thr_lo; // Skipped window after idle reads as in-band
        end
        if (!s.tx_mode || !s.loop_en) begin
          next_s.alc_st = FMTC_ALC_IDLE;
        end
      end
    endcase
    if (s.alc_st == FMTC_ALC_IDLE) begin
      next_s.peak = s.thr_lo;
    end

    // Register write path
    // Address and data in either order
    if (s_axi_awvalid && !s.aw_got && !s.bvalid) begin
      next_s.aw_got = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s.w_got && !s.bvalid) begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    // Byte strobes merge into current value
    cur = '0;
    if (s.aw_addr == REG_CTRL) begin
      cur[CTRL_LOOP_EN] = s.loop_en;
    end else if (s.aw_addr == REG_THRESH) begin
      cur[THR_LO_LSB +: FB_W] = s.thr_lo;
      cur[THR_HI_LSB +: FB_W] = s.thr_hi;
    end
    for (int i = 0; i < 4; i++) begin
      merged[i*8 +: 8] = s.wstrb[i] ? s.wdata[i*8 +: 8] : cur[i*8 +: 8];
    end
    // Commit once both are held
    if (s.aw_got && s.w_got) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      if (s.aw_addr == REG_CTRL) begin
        next_s.loop_en = merged[CTRL_LOOP_EN];
      end else if (s.aw_addr == REG_THRESH) begin
        next_s.thr_lo = merged[THR_LO_LSB +: FB_W];
        next_s.thr_hi = merged[THR_HI_LSB +: FB_W];
      end else if (s.aw_addr != REG_STATUS && s.aw_addr != REG_PEAK) begin
        next_s.bresp = RESP_SLVERR;
      end
    end
    // Response stands until bready
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // Register read path
    // Data stands until rready
    if (s_axi_arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = '0;
      case (s_axi_araddr)
        REG_CTRL:   next_s.rdata[CTRL_LOOP_EN] = s.loop_en;
        REG_THRESH: next_s.rdata = {4'h0, s.thr_hi, 4'h0, s.thr_lo};
        REG_STATUS: next_s.rdata = {16'h0, 3'h0, s.gain, 4'h0, s.last_dec, s.timed_out,
                                    s.tx_mode};
        REG_PEAK:   next_s.rdata[FB_W-1:0] = s.last_peak;
        default:    next_s.rresp = RESP_SLVERR;
      endcase
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.pd <= 1'b1;
      s.sync1.rx_tx_select <= 1'b1;
      s.sync2.rx_tx_select <= 1'b1;
      s.dir_q <= 1'b1;
      s.alc_st <= FMTC_ALC_IDLE;
      s.last_dec <= FMTC_DEC_HOLD;
      s.gain <= GAIN_MIN;
      s.loop_en <= 1'b1;
      s.thr_lo <= THR_LO_RST;
      s.thr_hi <= THR_HI_RST;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready = ~s.aw_got & ~s.bvalid;
  assign s_axi_wready  = ~s.w_got & ~s.bvalid;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = ~s.rvalid;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;

  assign line.shared_bit_clock     = s.shared_clk;
  assign line.rx_data              = s.rx_data;
  assign line.demodulated_out      = s.demod_out;
  assign line.tx_filter_drive      = s.filt_drive;
  assign line.tx_active            = s.tx_mode;
  assign line.power_down           = s.pd;
  assign line.output_level_control = s.gain;

endmodule
`default_nettype wire
